// ===== hdl/vsp_defines.svh
// Register map, field positions, reset values and encodings of the velocity scaled PWM block.
`ifndef VSP_DEFINES_SVH
`define VSP_DEFINES_SVH

// ==========================================================================
// Register indices (byte address is four times the index)
// ==========================================================================
`define VSP_IDX_GENERAL_CONFIG   8'h00
`define VSP_IDX_CURRENT_CONFIG   8'h05
`define VSP_IDX_FULL_SCALE_VEL   8'h17
`define VSP_IDX_MODE_SWITCH_VEL  8'h1d
`define VSP_IDX_PERIOD_LENGTH    8'h1f
`define VSP_IDX_MICROSTEP_SHIFT  8'h79
`define VSP_IDX_DRIVER_FORMAT    8'h70
`define VSP_IDX_IRQ_STATUS       8'h71
`define VSP_IDX_IRQ_MASK         8'h72

// ==========================================================================
// Field positions
// ==========================================================================
`define VSP_BIT_PWM_OUT_EN       21
`define VSP_BIT_PWM_SCALE_EN     8
`define VSP_AMPL_MSB             31
`define VSP_AMPL_LSB             16
`define VSP_ST_OVERCURRENT_A     0
`define VSP_ST_OVERCURRENT_B     1
`define VSP_ST_OVERTEMP          2
`define VSP_ST_MODE_CHANGE       3

// ==========================================================================
// Reset values and encodings
// ==========================================================================
`define VSP_RST_WORD             32'h0000_0000
`define VSP_RST_SHIFT            8'h00
`define VSP_RST_FORMAT           4'h0
`define VSP_RST_IRQ              4'h0
`define VSP_FMT_VOLT_DRV_A       4'h8
`define VSP_FMT_VOLT_DRV_B       4'h9
`define VSP_RESP_OKAY            2'b00
`define VSP_RESP_SLVERR          2'b10
`define VSP_SCALE_HALF           17'h1_0000
`define VSP_RATIO_FULL           17'h1_0000
`define VSP_DIV_STEPS            6'h2f
`define VSP_SCALE_SHIFT          25
`define VSP_HOLD_SHIFT           8
`define VSP_SHIFT_MAX            8'hff

`endif

// ===== hdl/vsp_pkg.sv
// Types shared by the velocity scaled PWM block.
package vsp_pkg;

  typedef enum logic [0:0] {
    VSP_DIV_LOAD,
    VSP_DIV_RUN
  } vsp_div_state_t;

endpackage

// ===== hdl/vsp_pwm_top.sv
// Velocity scaled two-coil PWM generator with voltage-mode driver pin steering and AXI4-Lite registers.
//
// Functional notes
// - PWM enable swaps step/dir for coil PWM
// - Period lasts exactly the programmed cycle count
// - Coil A follows sine, coil B cosine
// - Velocity scaling only when scale enable set
// - Amplitude field sets zero velocity scale
// - Zero velocity scale is (amplitude+1)/2^17
// - Scale rises linearly, saturates 0.5 at limit
// - Duty bounded by 0.5 minus/plus scale
// - Hold scale used at standstill when enabled
// - Voltage driver format in PWM mode disables serial, steers PWM to driver pins
// - Driver clock pin phase A, select phase B
// - Aux mode pin low in driver PWM
// - Driver data out pin held high
// - Driver fault flag sets three status bits
// - PWM disabled restores serial, aux pin high
// - Nonzero switch velocity selects mode by speed
// - Write-only offset shifts table value in PWM
//
// The implementer's own choice: register access over AXI4-Lite.
`include "vsp_defines.svh"

module vsp_pwm_top #(
  parameter int TW = 9,
  parameter int PW = 16
) (
  input  wire logic                 clock,
  input  wire logic                 reset_n,
  input  wire logic [9:0]           s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [9:0]           s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  input  wire logic signed [31:0]   ramp_velocity,
  input  wire logic signed [TW-1:0] microstep_sine,
  input  wire logic signed [TW-1:0] microstep_cosine,
  input  wire logic                 hold_scale_en,
  input  wire logic [7:0]           hold_scale_val,
  input  wire logic                 step_in,
  input  wire logic                 dir_in,
  input  wire logic                 serial_clock_in,
  input  wire logic                 serial_select_in,
  input  wire logic                 serial_data_in,
  input  wire logic                 driver_fault_in,
  output logic                      coil_a_out_pin,
  output logic                      coil_b_out_pin,
  output logic                      driver_clock_pin,
  output logic                      driver_select_pin,
  output logic                      driver_data_out_pin,
  output logic                      aux_mode_select_pin,
  output logic                      serial_if_enable,
  output logic                      irq
);

  // ==========================================================================
  // Registers
  // ==========================================================================
  logic [31:0] gen_cfg_r;
  logic [31:0] cur_cfg_r;
  logic [31:0] vmax_r;
  logic [31:0] switch_vel_r;
  logic [31:0] period_r;
  logic [7:0]  shift_r;
  logic [3:0]  fmt_r;
  logic [3:0]  irq_stat_r;
  logic [3:0]  irq_mask_r;
  logic        wr_en;
  logic [7:0]  wr_idx;
  logic [3:0]  stat_set;
  logic        pwm_mode_r;

  assign wr_en  = s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
  assign wr_idx = s_axi_awaddr[9:2];

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
      begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return r;
  endfunction

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      gen_cfg_r    <= `VSP_RST_WORD;
      cur_cfg_r    <= `VSP_RST_WORD;
      vmax_r       <= `VSP_RST_WORD;
      switch_vel_r <= `VSP_RST_WORD;
      period_r     <= `VSP_RST_WORD;
      shift_r      <= `VSP_RST_SHIFT;
      fmt_r        <= `VSP_RST_FORMAT;
      irq_mask_r   <= `VSP_RST_IRQ;
    end
    else if (wr_en)
    begin
      case (wr_idx)
        `VSP_IDX_GENERAL_CONFIG:  gen_cfg_r    <= merge(gen_cfg_r, s_axi_wdata, s_axi_wstrb);
        `VSP_IDX_CURRENT_CONFIG:  cur_cfg_r    <= merge(cur_cfg_r, s_axi_wdata, s_axi_wstrb);
        `VSP_IDX_FULL_SCALE_VEL:  vmax_r       <= merge(vmax_r, s_axi_wdata, s_axi_wstrb);
        `VSP_IDX_MODE_SWITCH_VEL: switch_vel_r <= merge(switch_vel_r, s_axi_wdata, s_axi_wstrb);
        `VSP_IDX_PERIOD_LENGTH:   period_r     <= merge(period_r, s_axi_wdata, s_axi_wstrb);
        `VSP_IDX_MICROSTEP_SHIFT: shift_r      <= s_axi_wstrb[0] ? s_axi_wdata[7:0] : shift_r;
        `VSP_IDX_DRIVER_FORMAT:   fmt_r        <= s_axi_wstrb[0] ? s_axi_wdata[3:0] : fmt_r;
        `VSP_IDX_IRQ_MASK:        irq_mask_r   <= s_axi_wstrb[0] ? s_axi_wdata[3:0] : irq_mask_r;
        default:                  ;
      endcase
    end
  end

  // Status bits: hardware set wins over a write-one-to-clear in the same cycle.
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      irq_stat_r <= `VSP_RST_IRQ;
    end
    else
    begin
      irq_stat_r <= (irq_stat_r & ~((wr_en && wr_idx == `VSP_IDX_IRQ_STATUS && s_axi_wstrb[0])
                                   ? s_axi_wdata[3:0] : 4'h0)) | stat_set;
    end
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      irq <= 1'b0;
    end
    else
    begin
      irq <= |(irq_stat_r & irq_mask_r);
    end
  end

  // ==========================================================================
  // AXI4-Lite handshakes
  // ==========================================================================
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `VSP_RESP_OKAY;
    end
    else
    begin
      s_axi_awready <= wr_en;
      s_axi_wready  <= wr_en;
      if (wr_en)
      begin
        s_axi_bvalid <= 1'b1;
        case (wr_idx)
          `VSP_IDX_GENERAL_CONFIG, `VSP_IDX_CURRENT_CONFIG, `VSP_IDX_FULL_SCALE_VEL,
          `VSP_IDX_MODE_SWITCH_VEL, `VSP_IDX_PERIOD_LENGTH, `VSP_IDX_MICROSTEP_SHIFT,
          `VSP_IDX_DRIVER_FORMAT, `VSP_IDX_IRQ_STATUS, `VSP_IDX_IRQ_MASK:
            s_axi_bresp <= `VSP_RESP_OKAY;
          default:
            s_axi_bresp <= `VSP_RESP_SLVERR;
        endcase
      end
      else if (s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  logic rd_en;
  assign rd_en = s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= `VSP_RST_WORD;
      s_axi_rresp   <= `VSP_RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= rd_en;
      if (rd_en)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `VSP_RESP_OKAY;
        case (s_axi_araddr[9:2])
          `VSP_IDX_GENERAL_CONFIG:  s_axi_rdata <= gen_cfg_r;
          `VSP_IDX_CURRENT_CONFIG:  s_axi_rdata <= cur_cfg_r;
          `VSP_IDX_FULL_SCALE_VEL:  s_axi_rdata <= vmax_r;
          `VSP_IDX_MODE_SWITCH_VEL: s_axi_rdata <= switch_vel_r;
          `VSP_IDX_PERIOD_LENGTH:   s_axi_rdata <= period_r;
          `VSP_IDX_MICROSTEP_SHIFT: s_axi_rdata <= `VSP_RST_WORD;
          `VSP_IDX_DRIVER_FORMAT:   s_axi_rdata <= {28'h0, fmt_r};
          `VSP_IDX_IRQ_STATUS:      s_axi_rdata <= {27'h0, pwm_mode_r, irq_stat_r};
          `VSP_IDX_IRQ_MASK:        s_axi_rdata <= {28'h0, irq_mask_r};
          default:
          begin
            s_axi_rdata <= `VSP_RST_WORD;
            s_axi_rresp <= `VSP_RESP_SLVERR;
          end
        endcase
      end
      else if (s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Mode selection
  // ==========================================================================
  logic [31:0] vabs;
  logic        pwm_mode;
  logic        drv_mode;

  assign vabs     = ramp_velocity[31] ? 32'(-ramp_velocity) : 32'(ramp_velocity);
  assign pwm_mode = gen_cfg_r[`VSP_BIT_PWM_OUT_EN] && ((switch_vel_r == 32'h0) || (vabs < switch_vel_r));
  assign drv_mode = pwm_mode && (fmt_r == `VSP_FMT_VOLT_DRV_A || fmt_r == `VSP_FMT_VOLT_DRV_B);

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pwm_mode_r <= 1'b0;
    end
    else
    begin
      pwm_mode_r <= pwm_mode;
    end
  end

  // The fault line only carries the driver's flag once the mode pin has already left serial mode.
  logic fault_seen;
  assign fault_seen = drv_mode && !aux_mode_select_pin && driver_fault_in;

  always_comb
  begin
    stat_set                        = 4'h0;
    stat_set[`VSP_ST_MODE_CHANGE]   = pwm_mode_r != pwm_mode;
    stat_set[`VSP_ST_OVERCURRENT_A] = fault_seen;
    stat_set[`VSP_ST_OVERCURRENT_B] = fault_seen;
    stat_set[`VSP_ST_OVERTEMP]      = fault_seen;
  end

  // ==========================================================================
  // Velocity ratio divider: ratio = |v| * 2^16 / full_scale_velocity
  // ==========================================================================
  vsp_pkg::vsp_div_state_t div_st_r;
  logic [5:0]  div_cnt_r;
  logic [47:0] dvd_r;
  logic [31:0] dvs_r;
  logic [32:0] rem_r;
  logic [16:0] quo_r;
  logic [16:0] ratio_r;
  logic [32:0] rem_sh;
  logic        q_bit;

  assign rem_sh = {rem_r[31:0], dvd_r[47]};
  assign q_bit  = rem_sh >= {1'b0, dvs_r};

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      div_st_r  <= vsp_pkg::VSP_DIV_LOAD;
      div_cnt_r <= 6'h0;
      dvd_r     <= 48'h0;
      dvs_r     <= 32'h0;
      rem_r     <= 33'h0;
      quo_r     <= 17'h0;
      ratio_r   <= 17'h0;
    end
    else
    begin
      case (div_st_r)
        vsp_pkg::VSP_DIV_LOAD:
        begin
          dvd_r     <= {((vabs > vmax_r) ? vmax_r : vabs), 16'h0};
          dvs_r     <= vmax_r;
          rem_r     <= 33'h0;
          quo_r     <= 17'h0;
          div_cnt_r <= `VSP_DIV_STEPS;
          div_st_r  <= vsp_pkg::VSP_DIV_RUN;
        end
        vsp_pkg::VSP_DIV_RUN:
        begin
          rem_r     <= q_bit ? 33'(rem_sh - {1'b0, dvs_r}) : rem_sh;
          quo_r     <= {quo_r[15:0], q_bit};
          dvd_r     <= {dvd_r[46:0], 1'b0};
          div_cnt_r <= div_cnt_r - 6'h1;
          if (div_cnt_r == 6'h0)
          begin
            ratio_r  <= (dvs_r == 32'h0) ? `VSP_RATIO_FULL : {quo_r[15:0], q_bit};
            div_st_r <= vsp_pkg::VSP_DIV_LOAD;
          end
        end
        default: div_st_r <= vsp_pkg::VSP_DIV_LOAD;
      endcase
    end
  end

  // ==========================================================================
  // Scale value in units of 2^-17
  // ==========================================================================
  logic [16:0] amp0;
  logic [33:0] span_prod;
  logic [16:0] scale;

  assign amp0      = 17'(cur_cfg_r[`VSP_AMPL_MSB:`VSP_AMPL_LSB]) + 17'h1;
  assign span_prod = (`VSP_SCALE_HALF - amp0) * ratio_r;

  always_comb
  begin
    if (!cur_cfg_r[`VSP_BIT_PWM_SCALE_EN])
    begin
      scale = `VSP_SCALE_HALF;
    end
    else if (hold_scale_en && vabs == 32'h0)
    begin
      scale = 17'(({9'h0, hold_scale_val} + 17'h1) << `VSP_HOLD_SHIFT);
    end
    else
    begin
      scale = amp0 + span_prod[32:16];
    end
  end

  // ==========================================================================
  // Duty thresholds and period counter
  // ==========================================================================
  logic [PW-1:0] cnt_r;
  logic [PW-1:0] cmp_a_r;
  logic [PW-1:0] cmp_b_r;
  logic [PW-1:0] period;
  logic          boundary;
  logic [PW-1:0] cmp_a;
  logic [PW-1:0] cmp_b;
  logic          pwm_a;
  logic          pwm_b;

  assign period   = period_r[PW-1:0];
  assign boundary = (cnt_r >= period - PW'(1)) || (period == '0);

  // Offset the table value away from zero while in PWM mode, saturating at full scale.
  function automatic logic [PW-1:0] duty(input logic signed [TW-1:0] t, input logic [16:0] sc,
                                          input logic [PW-1:0] per, input logic [7:0] sh, input logic en);
    logic signed [TW+1:0] ts;
    logic signed [TW+1:0] lim;
    logic signed [PW+TW+20:0] prod;
    logic signed [PW+1:0] res;
    ts   = (TW+2)'(t);
    lim  = (TW+2)'(`VSP_SHIFT_MAX);
    if (en)
    begin
      ts = (t < 0) ? ts - (TW+2)'(sh) : ts + (TW+2)'(sh);
      ts = (ts > lim) ? lim : ((ts < -lim) ? -lim : ts);
    end
    prod = $signed({1'b0, per}) * $signed({1'b0, sc}) * ts;
    res  = $signed({2'b0, per >> 1}) + (PW+2)'(prod >>> `VSP_SCALE_SHIFT);
    if (res < 0)
    begin
      return '0;
    end
    else if (res > $signed({2'b0, per}))
    begin
      return per;
    end
    return res[PW-1:0];
  endfunction

  assign cmp_a = duty(microstep_sine, scale, period, shift_r, pwm_mode);
  assign cmp_b = duty(microstep_cosine, scale, period, shift_r, pwm_mode);
  assign pwm_a = pwm_mode && (cnt_r < cmp_a_r);
  assign pwm_b = pwm_mode && (cnt_r < cmp_b_r);

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cnt_r   <= '0;
      cmp_a_r <= '0;
      cmp_b_r <= '0;
    end
    else if (boundary)
    begin
      cnt_r   <= '0;
      cmp_a_r <= cmp_a;
      cmp_b_r <= cmp_b;
    end
    else
    begin
      cnt_r <= cnt_r + PW'(1);
    end
  end

  // ==========================================================================
  // Pin steering
  // ==========================================================================
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      coil_a_out_pin      <= 1'b0;
      coil_b_out_pin      <= 1'b0;
      driver_clock_pin    <= 1'b0;
      driver_select_pin   <= 1'b1;
      driver_data_out_pin <= 1'b0;
      aux_mode_select_pin <= 1'b1;
      serial_if_enable    <= 1'b1;
    end
    else
    begin
      coil_a_out_pin      <= pwm_mode ? pwm_a : step_in;
      coil_b_out_pin      <= pwm_mode ? pwm_b : dir_in;
      driver_clock_pin    <= drv_mode ? pwm_a : serial_clock_in;
      driver_select_pin   <= drv_mode ? pwm_b : serial_select_in;
      driver_data_out_pin <= drv_mode ? 1'b1 : serial_data_in;
      aux_mode_select_pin <= !drv_mode;
      serial_if_enable    <= !drv_mode;
    end
  end

  // ==========================================================================
  // Checks
  // ==========================================================================
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  chk_coil_step_pass: assert property (!pwm_mode |=> coil_a_out_pin == $past(step_in))
    else $error("coil A pin does not follow step outside PWM mode");
  chk_period_wrap: assert property ((cnt_r == period - PW'(1)) && period > PW'(1) |=> cnt_r == '0)
    else $error("period counter did not wrap at programmed length");
  chk_scale_off: assert property (!cur_cfg_r[`VSP_BIT_PWM_SCALE_EN] |-> scale == `VSP_SCALE_HALF)
    else $error("scale not at half when scaling disabled");
  chk_zero_vel_scale: assert property (cur_cfg_r[`VSP_BIT_PWM_SCALE_EN] && !hold_scale_en && vabs == 32'h0
                                       && ratio_r == 17'h0 |-> scale == amp0)
    else $error("zero velocity scale differs from amplitude plus one");
  chk_scale_sat: assert property (ratio_r == `VSP_RATIO_FULL && cur_cfg_r[`VSP_BIT_PWM_SCALE_EN]
                                  && !(hold_scale_en && vabs == 32'h0) |-> scale == `VSP_SCALE_HALF)
    else $error("scale not saturated at full scale velocity");
  chk_drv_pins: assert property (drv_mode |=> !aux_mode_select_pin && driver_data_out_pin && !serial_if_enable)
    else $error("driver pins wrong in driver PWM mode");
  chk_serial_back: assert property ($fell(drv_mode) |-> ##1 aux_mode_select_pin && serial_if_enable)
    else $error("serial mode not restored after PWM disable");
  chk_fault_set: assert property (drv_mode && !aux_mode_select_pin && driver_fault_in |=> irq_stat_r[2:0] == 3'h7)
    else $error("driver fault did not set status bits");
  chk_cmp_stable: assert property (!boundary |=> $stable(cmp_a_r) && $stable(cmp_b_r))
    else $error("thresholds changed inside a period");
  chk_drv_clock: assert property (drv_mode |=> driver_clock_pin == $past(pwm_a))
    else $error("driver clock pin does not carry phase A");

  cov_drv_mode: cover property (drv_mode ##1 driver_fault_in);
  cov_switch_vel: cover property (gen_cfg_r[`VSP_BIT_PWM_OUT_EN] && switch_vel_r != 32'h0 && $fell(pwm_mode));
  cov_pwm_pulse: cover property (pwm_mode && $rose(coil_a_out_pin) ##[1:50] $fell(coil_a_out_pin));
  cov_irq: cover property ($rose(irq));

endmodule

// ===== dv/vsp_drv_model.sv
// Behavioural model of the voltage-mode stepper power driver facing the PWM block.
module vsp_drv_model (
  input  wire logic clock,
  input  wire logic driver_serial_mode_input,
  input  wire logic driver_coil_b_mode_input,
  input  wire logic fault_cmd,
  output logic      fault_flag
);
  timeunit 1ns;
  timeprecision 1ns;
  logic idle_r = 1'b0;
  // In serial mode the driver does not report faults on this line, so it toggles instead of holding a value.
  always_ff @(posedge clock)
  begin
    idle_r <= ~idle_r;
  end
  assign fault_flag = (!driver_serial_mode_input && driver_coil_b_mode_input) ? fault_cmd : idle_r;
endmodule

// ===== dv/tb.sv
// Self-checking testbench of the velocity scaled PWM block.
`include "vsp_defines.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clock, reset_n, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
  logic [9:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd_v;
  logic [1:0]  bresp, rresp, rsp;
  logic signed [31:0] vel;
  logic signed [8:0]  sine, cosine;
  logic        hold_en, step_in, dir_in, sclk, ssel, sdat, fault_cmd, fault, ca, cb, dclk, dsel, ddat, aux, sen, irq;
  logic [7:0]  hold_val;
  logic [3:0]  pins;
  int          n_fail, n_tests, cyc;
  assign pins = {dsel, dclk, cb, ca};

  vsp_pwm_top i_dut (.clock(clock), .reset_n(reset_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .ramp_velocity(vel), .microstep_sine(sine),
    .microstep_cosine(cosine), .hold_scale_en(hold_en), .hold_scale_val(hold_val), .step_in(step_in),
    .dir_in(dir_in), .serial_clock_in(sclk), .serial_select_in(ssel), .serial_data_in(sdat),
    .driver_fault_in(fault), .coil_a_out_pin(ca), .coil_b_out_pin(cb), .driver_clock_pin(dclk),
    .driver_select_pin(dsel), .driver_data_out_pin(ddat), .aux_mode_select_pin(aux), .serial_if_enable(sen),
    .irq(irq));
  vsp_drv_model i_drv (.clock(clock), .driver_serial_mode_input(aux), .driver_coil_b_mode_input(ddat),
    .fault_cmd(fault_cmd), .fault_flag(fault));

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic w(input logic [7:0] idx, input logic [31:0] d);
    @(posedge clock);
    awaddr <= {idx, 2'b00};
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clock);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk("bresp", `VSP_RESP_OKAY, bresp);
  endtask
  task automatic rd(input logic [7:0] idx);
    @(posedge clock);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge clock);
      if (arready === 1'b1) arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1);
    rready <= 1'b0;
    rd_v = rdata;
    rsp = rresp;
  endtask
  // Expected high cycles per period: half period plus period times scale times table value over 2^25.
  task automatic duty(input int sel, input int p, input longint sc, input longint t);
    logic [31:0] n;
    n = 0;
    repeat (200) @(posedge clock);
    repeat (p) @(posedge clock) n = n + pins[sel];
    chk("duty", p / 2 + ((p * sc * t) >>> 25), n);
  endtask
  task automatic t_reset();
    chk("aux", 1, aux);
    chk("sen", 1, sen);
    rd(`VSP_IDX_GENERAL_CONFIG);
    chk("gconf", 0, rd_v);
    w(`VSP_IDX_MICROSTEP_SHIFT, 32'h0000_0032);
    rd(`VSP_IDX_MICROSTEP_SHIFT);
    chk("shift", 0, rd_v);
    rd(8'h40);
    chk("unmapped", `VSP_RESP_SLVERR, rsp);
    step_in <= 1'b1;
    dir_in <= 1'b1;
    sclk <= 1'b1;
    sdat <= 1'b1;
    repeat (3) @(posedge clock);
    chk("fwd", 5'b10111, {ddat, dsel, dclk, cb, ca});
    $display("test reset done");
  endtask
  task automatic t_duty();
    w(`VSP_IDX_PERIOD_LENGTH, 32'h0000_000c);
    w(`VSP_IDX_GENERAL_CONFIG, 32'h0020_0000);
    duty(0, 12, 65536, 50);
    w(`VSP_IDX_PERIOD_LENGTH, 32'h0000_0010);
    duty(1, 16, 65536, -255);
    sine <= 9'sd100;
    duty(0, 16, 65536, 150);
    $display("test duty done");
  endtask
  task automatic t_scale();
    sine <= 9'sd255;
    w(`VSP_IDX_FULL_SCALE_VEL, 32'd1000);
    w(`VSP_IDX_CURRENT_CONFIG, 32'h0000_0100);
    duty(0, 16, 1, 255);
    hold_en <= 1'b1;
    duty(0, 16, 32768, 255);
    hold_en <= 1'b0;
    w(`VSP_IDX_CURRENT_CONFIG, 32'h7fff_0100);
    duty(0, 16, 32768, 255);
    vel <= 500;
    duty(0, 16, 49152, 255);
    vel <= -2000;
    duty(0, 16, 65536, 255);
    vel <= 0;
    w(`VSP_IDX_CURRENT_CONFIG, 32'h7fff_0000);
    duty(0, 16, 65536, 255);
    $display("test scale done");
  endtask
  task automatic t_driver();
    sine <= 9'sd0;
    w(`VSP_IDX_DRIVER_FORMAT, `VSP_FMT_VOLT_DRV_B);
    repeat (3) @(posedge clock);
    chk("drvb", 3'b100, {ddat, aux, sen});
    w(`VSP_IDX_DRIVER_FORMAT, `VSP_FMT_VOLT_DRV_A);
    duty(2, 16, 65536, 50);
    duty(3, 16, 65536, -255);
    chk("drva", 3'b100, {ddat, aux, sen});
    @(posedge clock) fault_cmd <= 1'b1;
    @(posedge clock) fault_cmd <= 1'b0;
    rd(`VSP_IDX_IRQ_STATUS);
    chk("fault", 3'h7, rd_v[2:0]);
    chk("masked", 0, irq);
    w(`VSP_IDX_IRQ_MASK, 32'h0000_0007);
    repeat (2) @(posedge clock);
    chk("irq", 1, irq);
    w(`VSP_IDX_IRQ_STATUS, 32'h0000_000f);
    repeat (2) @(posedge clock);
    chk("irq clr", 0, irq);
    $display("test driver done");
  endtask
  task automatic t_switch();
    w(`VSP_IDX_MODE_SWITCH_VEL, 32'd100);
    vel <= 99;
    repeat (3) @(posedge clock);
    chk("below", 0, aux);
    vel <= -100;
    repeat (3) @(posedge clock);
    chk("at", 3'b111, {ddat, aux, sen});
    vel <= 0;
    w(`VSP_IDX_GENERAL_CONFIG, 0);
    repeat (3) @(posedge clock);
    chk("off", 4'b1111, {aux, sen, ddat, ca});
    $display("test switch done");
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial
  begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_fail++;
      conclude();
    end
  end
  initial
  begin
    {reset_n, awvalid, wvalid, bready, arvalid, rready, hold_en, step_in, dir_in, sclk, ssel, sdat, fault_cmd} = 0;
    {awaddr, araddr, wdata, vel, sine, cosine} = 0;
    cosine = -9'sd256;
    hold_val = 8'h7f;
    repeat (2) @(posedge clock);
    reset_n <= 1'b1;
    t_reset();
    t_duty();
    t_scale();
    t_driver();
    t_switch();
    conclude();
  end
endmodule
